// ---- hw/bus_arbiter.sv ----
// two-clock bus cycle sequencer with operand priority over prefetch
`timescale 1ns/1ps
`include "sched_cfg.svh"
module bus_arbiter import sched_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] bus_clocks,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic pf_req,
  output logic rd_gnt,
  output logic wr_gnt,
  output logic pf_gnt,
  output bus_cyc_t bus
);
  bus_cyc_t bus_r;
  bus_cyc_t bus_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic can;
  // a new cycle may start in the last clock of the current one
  assign can = !bus_r.valid || cnt_r == 4'h0;
  assign wr_gnt = can && wr_req;
  assign rd_gnt = can && rd_req && !wr_req;
  assign pf_gnt = can && pf_req && !rd_req && !wr_req;
  assign bus = bus_r;
  always_comb begin
    bus_nxt = bus_r;
    cnt_nxt = cnt_r;
    if (can) begin
      bus_nxt.valid = rd_gnt || wr_gnt || pf_gnt;
      bus_nxt.kind = wr_gnt ? ACC_WR : (rd_gnt ? ACC_RD : ACC_PF);
      // slow memory stretches each access beyond the two-clock baseline
      cnt_nxt = (bus_clocks > `BASE_BUS_CLK ? bus_clocks : `BASE_BUS_CLK) - 4'd1;
    end else begin
      cnt_nxt = cnt_r - 4'd1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bus_r <= '{1'b0, ACC_RD};
      cnt_r <= 4'h0;
    end else begin
      bus_r <= bus_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_OP_PRIO: assert property ((rd_req || wr_req) |-> !pf_gnt)
    else $error("prefetch granted over operand access");
  AST_BUS_LEN: assert property ((rd_gnt || wr_gnt || pf_gnt) && bus_clocks == 4'd2 |=>
    bus_r.valid && cnt_r == 4'd1 ##1 bus_r.valid && cnt_r == 4'd0)
    else $error("two-clock bus cycle has wrong length");
endmodule // bus_arbiter

// ---- hw/ea_bus_timing_scheduler.sv ----
// instruction and effective-address timing scheduler issuing bus cycles
`timescale 1ns/1ps
`include "sched_cfg.svh"
// What this block does
// - baseline timing uses sixteen-bit two-clock cycles
// - every instruction refills the pipeline before finishing
// - head cycles finish prior write or prefetch
// - tail cycles carry the instruction's final write
// - report cycles, head, tail, overlap and internal clocks
// - long operands take two accesses, plus two
// - trailing write overlaps next head, counted once
// - head taken by write defers prefetches later
// - negative tail lets next prefetch start early
// - word extension waits one cycle in pipeline
// - eight-bit indexed mode: head4 tail2 cycles8
// - address-fetch read overlaps next head by tail
// - index size and scale never change timing
// - program counter base times like address base
// - slow prefetch eats head first, then tail/total
// - calculate mode is fetch without operand read
// - internal clocks are two-clock total minus two per access
// - each slow read or write adds its extra clocks
// - overlap is min of previous tail, head
// - operand accesses beat prefetches on the bus
module ea_bus_timing_scheduler import sched_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire ins_desc_t ins,
  input wire logic ins_valid,
  output logic ins_ready,
  input wire logic ext_word_ok,
  input wire logic [3:0] bus_clocks,
  output bus_cyc_t bus,
  output logic done,
  output timing_rpt_t rpt,
  output logic [15:0] run_total
);
  typedef enum logic {ST_IDLE, ST_RUN} st_t;
  st_t st_r;
  st_t st_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [3:0] rd_left_r;
  logic [3:0] rd_left_nxt;
  logic [3:0] pf_left_r;
  logic [3:0] pf_left_nxt;
  logic [3:0] wr_left_r;
  logic [3:0] wr_left_nxt;
  logic signed [5:0] tail_r;
  logic signed [5:0] tail_nxt;
  logic signed [5:0] prev_tail_r;
  logic signed [5:0] prev_tail_nxt;
  logic early_r;
  logic early_nxt;
  logic ext_age_r;
  logic ext_age_nxt;
  logic done_r;
  logic done_nxt;
  timing_rpt_t rpt_r;
  timing_rpt_t rpt_nxt;
  logic [15:0] total_r;
  logic [15:0] total_nxt;
  ea_time_t ea;
  logic ea_on;
  logic [3:0] h0;
  logic [3:0] h1;
  logic [3:0] ov_ea;
  logic [3:0] prev_pos;
  logic [3:0] ovl;
  logic [3:0] wr_n;
  logic [4:0] r_n;
  logic [4:0] p_n;
  logic [7:0] acc_n;
  logic [7:0] c0;
  logic [7:0] c1;
  logic [7:0] ex8;
  logic [7:0] pf_ex;
  logic [7:0] spill;
  logic [7:0] rw_ex;
  logic [7:0] len;
  logic [7:0] internal;
  logic [7:0] tail_pos;
  logic signed [5:0] t0;
  logic signed [5:0] t1;
  logic long_wr;
  logic ext_need;
  logic fin;
  logic start;
  logic rd_req;
  logic wr_req;
  logic pf_req;
  logic early_want;
  logic rd_gnt;
  logic wr_gnt;
  logic pf_gnt;

  ea_time_lut u_lut (
    .mode(ins.mode),
    .calc(ins.calc),
    .long_op(ins.long_op),
    .tm(ea)
  );

  bus_arbiter u_arb (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bus_clocks(bus_clocks),
    .rd_req(rd_req),
    .wr_req(wr_req),
    .pf_req(pf_req),
    .rd_gnt(rd_gnt),
    .wr_gnt(wr_gnt),
    .pf_gnt(pf_gnt),
    .bus(bus)
  );

  // timing of the presented instruction, ea part folded into the operation
  always_comb begin
    ea_on = ea.cyc != 4'h0;
    long_wr = ins.op_wr_var && ins.long_op;
    ov_ea = (ea.tail < ins.op_head) ? ea.tail : ins.op_head;
    h0 = ea_on ? ea.head : ins.op_head;
    c0 = ea_on ? ({4'h0, ea.cyc} - {4'h0, ov_ea} + ins.op_cyc) : ins.op_cyc;
    c0 = c0 + (long_wr ? `LONG_ADD : 8'h00);
    t0 = ins.op_tail + (long_wr ? 6'sd2 : 6'sd0);
    wr_n = ins.op_wr_var ? (ins.long_op ? `LONG_ACC : `WORD_ACC) : ins.op_wr;
    r_n = {1'b0, ea.rd} + {1'b0, ins.op_rd};
    p_n = {1'b0, ea.pf} + {1'b0, ins.op_pf};
    acc_n = {3'h0, r_n} + {3'h0, p_n} + {4'h0, wr_n};
    internal = c0 - 8'(acc_n * {4'h0, `BASE_BUS_CLK});
    ex8 = (bus_clocks > `BASE_BUS_CLK) ? {4'h0, bus_clocks - `BASE_BUS_CLK} : 8'h00;
    pf_ex = 8'({3'h0, p_n} * ex8);
    // extra prefetch clocks are soaked up by the head before they cost time
    if (pf_ex <= {4'h0, h0}) begin
      h1 = h0 - pf_ex[3:0];
      spill = 8'h00;
    end else begin
      h1 = 4'h0;
      spill = pf_ex - {4'h0, h0};
    end
    t1 = t0 + $signed(spill[5:0]);
    rw_ex = 8'({3'h0, r_n} * ex8) + 8'({4'h0, wr_n} * ex8);
    c1 = c0 + spill + rw_ex;
    // a negative tail counts as zero when crediting overlap
    // a take in the finishing cycle overlaps the instruction that is finishing now
    if (fin) begin
      prev_pos = tail_r[5] ? 4'h0 : tail_r[3:0];
    end else begin
      prev_pos = prev_tail_r[5] ? 4'h0 : prev_tail_r[3:0];
    end
    ovl = (prev_pos < h1) ? prev_pos : h1;
    len = (c1 > {4'h0, ovl}) ? c1 - {4'h0, ovl} : 8'h01;
    tail_pos = tail_r[5] ? 8'h00 : {2'b00, tail_r};
  end

  // only word extensions must settle; long offsets go straight in
  assign ext_need = ins.ext_word && !ins.long_disp;
  // the write buffer holds one entry, so the write must be granted first
  assign fin = st_r == ST_RUN && cnt_r == 8'h00 && rd_left_r == 4'h0 && pf_left_r == 4'h0 &&
    wr_left_r == 4'h0;
  assign start = ins_valid && (st_r == ST_IDLE || fin) && (!ext_need || ext_age_r);
  assign ins_ready = start;
  assign rd_req = st_r == ST_RUN && rd_left_r != 4'h0;
  assign wr_req = st_r == ST_RUN && wr_left_r != 4'h0 && rd_left_r == 4'h0 && cnt_r <= tail_pos;
  // free bus clocks at a change of flow fetch ahead for the next one
  // no early fetch in a take cycle: its credit would be lost with the restart
  assign early_want = st_r == ST_RUN && tail_r < 6'sd0 && cnt_r <= `EARLY_PF_WIN && !early_r &&
    pf_left_r == 4'h0 && !start;
  assign pf_req = (st_r == ST_RUN && pf_left_r != 4'h0) || early_want;
  assign done = done_r;
  assign rpt = rpt_r;
  assign run_total = total_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rd_left_nxt = rd_left_r;
    pf_left_nxt = pf_left_r;
    wr_left_nxt = wr_left_r;
    tail_nxt = tail_r;
    prev_tail_nxt = prev_tail_r;
    early_nxt = early_r;
    ext_age_nxt = ext_word_ok ? `MIN_EXT_AGE : 1'b0;
    done_nxt = fin;
    rpt_nxt = rpt_r;
    total_nxt = total_r;
    case (st_r)
      ST_IDLE: begin
        st_nxt = ST_IDLE;
      end
      ST_RUN: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end
        if (rd_gnt) begin
          rd_left_nxt = rd_left_r - 4'h1;
        end
        if (wr_gnt) begin
          wr_left_nxt = wr_left_r - 4'h1;
        end
        if (pf_gnt && pf_left_r != 4'h0) begin
          pf_left_nxt = pf_left_r - 4'h1;
        end else if (pf_gnt) begin
          early_nxt = 1'b1;
        end
        if (fin) begin
          st_nxt = ST_IDLE;
          prev_tail_nxt = tail_r;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (start) begin
      st_nxt = ST_RUN;
      cnt_nxt = len - 8'h01;
      rd_left_nxt = r_n[3:0];
      pf_left_nxt = (early_r && p_n != 5'h00) ? p_n[3:0] - 4'h1 : p_n[3:0];
      early_nxt = 1'b0;
      wr_left_nxt = wr_n;
      tail_nxt = t1;
      rpt_nxt = '{c1, h1, t1, ovl, internal};
      total_nxt = total_r + {8'h00, len};
    end else if (fin) begin
      // a finish with no take keeps the tail as overlap credit for the next instruction
      prev_tail_nxt = tail_r;
    end else if (st_r == ST_IDLE && !bus.valid) begin
      prev_tail_nxt = 6'sd0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
      cnt_r <= 8'h00;
      rd_left_r <= 4'h0;
      pf_left_r <= 4'h0;
      wr_left_r <= 4'h0;
      tail_r <= 6'sd0;
      prev_tail_r <= 6'sd0;
      early_r <= 1'b0;
      ext_age_r <= 1'b0;
      done_r <= 1'b0;
      rpt_r <= '0;
      total_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rd_left_r <= rd_left_nxt;
      pf_left_r <= pf_left_nxt;
      wr_left_r <= wr_left_nxt;
      tail_r <= tail_nxt;
      prev_tail_r <= prev_tail_nxt;
      early_r <= early_nxt;
      ext_age_r <= ext_age_nxt;
      done_r <= done_nxt;
      rpt_r <= rpt_nxt;
      total_r <= total_nxt;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence seq_take;
    ins_ready;
  endsequence
  sequence seq_finish;
    st_r == ST_RUN && cnt_r == 8'h00 ##1 done_r;
  endsequence

  AST_OVERLAP_MIN: assert property (seq_take |=> rpt_r.overlap <= $past(prev_pos) &&
    rpt_r.overlap <= rpt_r.head)
    else $error("overlap exceeds previous tail or head");
  AST_LEN_LOAD: assert property (seq_take |=> st_r == ST_RUN && cnt_r == $past(len) - 8'h01)
    else $error("run length not loaded from cycles minus overlap");
  AST_EXT_WAIT: assert property (seq_take and (ins.ext_word && !ins.long_disp) |-> $past(ext_word_ok))
    else $error("instruction began before extension word settled");
  AST_REFILL: assert property (seq_finish |-> $past(pf_left_r, 1) == 4'h0 && $past(wr_left_r, 1) == 4'h0)
    else $error("instruction finished with pipeline not refilled");
  AST_FAST_HEAD: assert property (seq_take and bus_clocks == 4'd2 |=> rpt_r.head == $past(h0) &&
    rpt_r.cyc == $past(c0))
    else $error("head or cycles altered on a two-clock bus");
  AST_INTERNAL: assert property (seq_take |=> rpt_r.internal + 8'($past(acc_n) * 8'd2) == $past(c0))
    else $error("internal clocks wrong");
  AST_WR_TAIL: assert property (wr_gnt |-> rd_left_r == 4'h0 && cnt_r <= tail_pos)
    else $error("write issued before tail");
  AST_EARLY_PF: assert property (early_want && pf_gnt |=> early_r [*1])
    else $error("early prefetch not credited");
endmodule // ea_bus_timing_scheduler

// ---- hw/ea_time_lut.sv ----
// per-mode head, tail, cycle and access lookup for fetch and calculate
`timescale 1ns/1ps
`include "sched_cfg.svh"
module ea_time_lut import sched_pkg::*; (
  input wire ea_mode_t mode,
  input wire logic calc,
  input wire logic long_op,
  output ea_time_t tm
);
  // nibbles: head, tail, cycles, prefetches
  logic [15:0] fv;
  logic [15:0] cv;
  logic xr;
  always_comb begin
    fv = 16'h0000;
    cv = 16'h0000;
    xr = 1'b1;
    case (mode)
      EA_DN, EA_AN: begin
        xr = 1'b0;
      end
      EA_IND, EA_POSTINC: begin
        fv = 16'h1130;
        cv = 16'h1020;
      end
      EA_PREDEC: begin
        fv = 16'h2240;
        cv = 16'h2020;
      end
      EA_D16, EA_ABSW: begin
        fv = 16'h1351;
        cv = 16'h1131;
      end
      EA_ABSL: begin
        fv = 16'h1572;
        cv = 16'h1352;
      end
      EA_IMMB, EA_IMMW: begin
        fv = 16'h1131;
        cv = 16'h1131;
        xr = 1'b0;
      end
      EA_IMML: begin
        fv = 16'h1352;
        cv = 16'h1352;
        xr = 1'b0;
      end
      EA_D8X, EA_MX, EA_MANX: begin
        fv = 16'h4281;
        cv = 16'h4061;
      end
      EA_SUPP: begin
        fv = 16'h2261;
        cv = 16'h2041;
      end
      EA_BD16, EA_MD16: begin
        fv = 16'h1372;
        cv = 16'h1152;
      end
      EA_BD32, EA_MD32: begin
        fv = 16'h1593;
        cv = 16'h1373;
      end
      EA_MIND: begin
        fv = 16'h1151;
        cv = 16'h1041;
      end
      EA_MD16X, EA_MD16XS: begin
        fv = 16'h2282;
        cv = 16'h2062;
      end
      EA_MD32X, EA_MD32XS: begin
        fv = 16'h1393;
        cv = 16'h1173;
      end
      default: begin
        xr = 1'b0;
      end
    endcase
    if (calc) begin
      // calculate form: same walk with no operand read
      tm = '{cv[15:12], cv[11:8], cv[7:4], 4'h0, cv[3:0]};
    end else if (xr && long_op) begin
      tm = '{fv[15:12], fv[11:8] + 4'd2, fv[7:4] + 4'd2, `LONG_ACC, fv[3:0]};
    end else begin
      tm = '{fv[15:12], fv[11:8], fv[7:4], xr ? `WORD_ACC : 4'h0, fv[3:0]};
    end
  end
endmodule // ea_time_lut

// ---- hw/sched_cfg.svh ----
// timing constants for the effective-address bus scheduler
`ifndef SCHED_CFG_SVH
`define SCHED_CFG_SVH
`define CLK_PERIOD_NS 5
`define BASE_BUS_CLK 4'd2
`define LONG_ADD 8'd2
`define LONG_ACC 4'd2
`define WORD_ACC 4'd1
`define MIN_EXT_AGE 1'b1
`define EARLY_PF_WIN 8'd2
`endif

// ---- hw/sched_pkg.sv ----
// types shared by the effective-address bus scheduler
package sched_pkg;
  // index size/scale and pc-vs-base do not select separate entries
  typedef enum logic [4:0] {
    EA_DN, EA_AN, EA_IND, EA_POSTINC, EA_PREDEC, EA_D16, EA_ABSW, EA_ABSL,
    EA_IMMB, EA_IMMW, EA_IMML, EA_D8X, EA_SUPP, EA_BD16, EA_BD32, EA_MIND,
    EA_MX, EA_MANX, EA_MD16, EA_MD32, EA_MD16X, EA_MD32X, EA_MD16XS, EA_MD32XS
  } ea_mode_t;
  typedef enum logic [1:0] {ACC_RD, ACC_PF, ACC_WR} acc_kind_t;
  typedef struct packed {
    ea_mode_t mode;
    logic calc;
    logic long_op;
    logic [3:0] op_head;
    logic signed [5:0] op_tail;
    logic [7:0] op_cyc;
    logic [3:0] op_rd;
    logic [3:0] op_pf;
    logic [3:0] op_wr;
    logic op_wr_var;
    logic ext_word;
    logic long_disp;
  } ins_desc_t;
  typedef struct packed {
    logic [3:0] head;
    logic [3:0] tail;
    logic [3:0] cyc;
    logic [3:0] rd;
    logic [3:0] pf;
  } ea_time_t;
  typedef struct packed {
    logic valid;
    acc_kind_t kind;
  } bus_cyc_t;
  typedef struct packed {
    logic [7:0] cyc;
    logic [3:0] head;
    logic signed [5:0] tail;
    logic [3:0] overlap;
    logic [7:0] internal;
  } timing_rpt_t;
endpackage

// ---- test/bus_mem_model.sv ----
// memory-side model: sets access length and counts bus accesses
`timescale 1ns/1ps
module bus_mem_model import sched_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire bus_cyc_t bus,
  input wire logic slow,
  output logic [3:0] bus_clocks,
  output int n_rd,
  output int n_pf,
  output int n_wr,
  output int n_bad
);
  logic [3:0] cnt_r;
  acc_kind_t kind_r;
  // one wait clock when slow, so stretched accesses get exercised
  assign bus_clocks = slow ? 4'h3 : 4'h2;
  always @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
      n_rd <= 0;
      n_pf <= 0;
      n_wr <= 0;
      n_bad <= 0;
    end else if (bus.valid) begin
      // kind must not change inside one access
      if (cnt_r != 4'h0 && bus.kind !== kind_r) n_bad <= n_bad + 1;
      kind_r <= bus.kind;
      if (cnt_r + 4'h1 >= bus_clocks) begin
        cnt_r <= 4'h0;
        if (bus.kind == ACC_RD) n_rd <= n_rd + 1;
        else if (bus.kind == ACC_PF) n_pf <= n_pf + 1;
        else n_wr <= n_wr + 1;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end else if (cnt_r != 4'h0) begin
      // access dropped before its clocks ran out
      n_bad <= n_bad + 1;
      cnt_r <= 4'h0;
    end
  end
endmodule // bus_mem_model

// ---- test/ea_bus_timing_scheduler_tb_top.sv ----
// self-checking bench for the effective-address bus scheduler
`timescale 1ns/1ps
module ea_bus_timing_scheduler_tb_top import sched_pkg::*; ;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  ins_desc_t ins = '0;
  logic ins_valid = 1'h0;
  logic ext_word_ok = 1'h1;
  logic slow = 1'h0;
  logic ins_ready, done;
  logic [3:0] bus_clocks;
  bus_cyc_t bus;
  timing_rpt_t rpt;
  logic [15:0] run_total;
  int n_rd, n_pf, n_wr, n_bad, waited;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 26;
  int e_rd = 0;
  int e_pf = 0;
  int e_wr = 0;
  int e_tot = 0;
  int prev_tail = 0;
  ea_mode_t modes [11] = '{EA_DN, EA_IND, EA_POSTINC, EA_PREDEC, EA_D16, EA_ABSW, EA_ABSL, EA_IMMW, EA_IMML,
    EA_D8X, EA_SUPP};

  always #2.5 ref_clk = ~ref_clk;

  ea_bus_timing_scheduler uut (.ref_clk(ref_clk), .resetn(resetn), .ins(ins), .ins_valid(ins_valid),
    .ins_ready(ins_ready), .ext_word_ok(ext_word_ok), .bus_clocks(bus_clocks), .bus(bus), .done(done),
    .rpt(rpt), .run_total(run_total));
  bus_mem_model mem (.ref_clk(ref_clk), .resetn(resetn), .bus(bus), .slow(slow), .bus_clocks(bus_clocks),
    .n_rd(n_rd), .n_pf(n_pf), .n_wr(n_wr), .n_bad(n_bad));

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_val(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %0d got %0d", nm, e, g);
    end
  endtask

  task automatic chk_bit(string nm, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask

  function automatic int rnd(int n);
    return $unsigned($random(seed)) % n;
  endfunction

  // word figures {head,tail,cyc,rd,pf}; a fetched long read adds one read and two clocks
  function automatic ea_time_t ea_exp(ins_desc_t d);
    ea_time_t t;
    case (d.mode)
      EA_IND, EA_POSTINC: t = d.calc ? 20'h10200 : 20'h11300;
      EA_PREDEC: t = d.calc ? 20'h20200 : 20'h22400;
      EA_D16, EA_ABSW: t = d.calc ? 20'h11301 : 20'h13501;
      EA_ABSL: t = d.calc ? 20'h13502 : 20'h15702;
      EA_D8X: t = d.calc ? 20'h40601 : 20'h42801;
      EA_SUPP: t = d.calc ? 20'h20401 : 20'h22601;
      EA_IMMW: t = 20'h11301;
      EA_IMML: t = 20'h13502;
      default: t = 20'h00000;
    endcase
    if (!d.calc && !(d.mode inside {EA_DN, EA_IMMW, EA_IMML})) begin
      t.rd = d.long_op ? 4'h2 : 4'h1;
      t.tail = t.tail + (d.long_op ? 4'h2 : 4'h0);
      t.cyc = t.cyc + (d.long_op ? 4'h2 : 4'h0);
    end
    return t;
  endfunction

  function automatic ins_desc_t mk(ea_mode_t m, logic c, logic l, int h, int tl, int cy, int rd, int pf,
    int wr, logic wv);
    ins_desc_t d;
    d = '0;
    d.mode = m;
    d.calc = c;
    d.long_op = l;
    d.op_head = 4'(h);
    d.op_tail = 6'(tl);
    d.op_cyc = 8'(cy);
    d.op_rd = 4'(rd);
    d.op_pf = 4'(pf);
    d.op_wr = 4'(wr);
    d.op_wr_var = wv;
    return d;
  endfunction

  // entered at a falling edge; leaves at the falling edge after the take
  task automatic send(ins_desc_t d, bit chk);
    ea_time_t t;
    int h, tl, c, w, ov, rd, pf, k;
    logic r;
    t = ea_exp(d);
    w = d.op_wr_var ? (d.long_op ? 2 : 1) : int'(d.op_wr);
    tl = int'(d.op_tail) + ((d.op_wr_var && d.long_op) ? 2 : 0);
    h = t.cyc != 4'h0 ? int'(t.head) : int'(d.op_head);
    c = int'(d.op_cyc) + ((d.op_wr_var && d.long_op) ? 2 : 0);
    if (t.cyc != 4'h0) c = c + t.cyc - (t.tail < d.op_head ? t.tail : d.op_head);
    ov = prev_tail < h ? prev_tail : h;
    rd = t.rd + d.op_rd;
    pf = t.pf + d.op_pf;
    ins = d;
    ins_valid = 1'h1;
    for (k = 0; k < 300; k++) begin
      #1 r = ins_ready;
      @(posedge ref_clk);
      if (r === 1'h1) break;
    end
    waited = k;
    if (k == 300) begin
      n_fail++;
      summarize();
    end
    @(negedge ref_clk);
    e_rd += rd;
    e_pf += pf;
    e_wr += w;
    if (chk) begin
      chk_val("cycles", 16'(c), 16'(rpt.cyc));
      chk_val("head", 16'(h), 16'(rpt.head));
      chk_val("tail", 16'(tl), 16'(rpt.tail));
      chk_val("overlap", 16'(ov), 16'(rpt.overlap));
      chk_val("internal", 16'(c - 2 * (rd + pf + w)), 16'(rpt.internal));
      e_tot += c - ov;
    end
    prev_tail = tl > 0 ? tl : 0;
  endtask

  task automatic quiesce();
    int k;
    ins_valid = 1'h0;
    @(negedge ref_clk);
    for (k = 0; k < 300 && done !== 1'h1; k++) @(negedge ref_clk);
    chk_bit("done", 1'h1, done);
    @(negedge ref_clk);
    chk_bit("done pulse", 1'h0, done);
    for (k = 0; k < 300 && bus.valid !== 1'h0; k++) @(negedge ref_clk);
    chk_bit("bus idle", 1'h0, bus.valid);
    @(negedge ref_clk);
    prev_tail = 0;
  endtask

  initial begin
    ins_desc_t d;
    int i;
    repeat (10) @(negedge ref_clk);
    chk_bit("rpt reset", 1'h1, rpt === '0);
    chk_bit("done reset", 1'h0, done);
    chk_bit("bus reset", 1'h0, bus.valid);
    chk_val("total reset", 16'h0, run_total);
    resetn = 1'h1;
    send(mk(EA_D8X, 1'h0, 1'h1, 0, 0, 2, 0, 1, 0, 1'h0), 1'h1);
    send(mk(EA_D8X, 1'h1, 1'h0, 0, 0, 2, 0, 1, 0, 1'h0), 1'h1);
    // long write tail fully hidden under the next head
    send(mk(EA_DN, 1'h0, 1'h1, 0, 2, 4, 0, 1, 0, 1'h1), 1'h1);
    send(mk(EA_DN, 1'h0, 1'h0, 4, 0, 6, 0, 1, 0, 1'h0), 1'h1);
    // negative tail earns no overlap credit
    send(mk(EA_DN, 1'h0, 1'h0, 4, -2, 10, 0, 3, 0, 1'h0), 1'h1);
    send(mk(EA_DN, 1'h0, 1'h0, 2, 0, 4, 0, 1, 0, 1'h0), 1'h1);
    quiesce();
    d = mk(EA_IMMW, 1'h0, 1'h0, 0, 0, 2, 0, 1, 0, 1'h0);
    d.ext_word = 1'h1;
    d.long_disp = 1'h1;
    ext_word_ok = 1'h0;
    send(d, 1'h1);
    chk_val("long disp wait", 16'h0, 16'(waited));
    quiesce();
    d.long_disp = 1'h0;
    ins = d;
    ins_valid = 1'h1;
    repeat (4) begin
      #1 chk_bit("ready early", 1'h0, ins_ready);
      @(negedge ref_clk);
    end
    ext_word_ok = 1'h1;
    #1 chk_bit("ready aged", 1'h0, ins_ready);
    @(negedge ref_clk);
    send(d, 1'h1);
    chk_val("aged wait", 16'h0, 16'(waited));
    quiesce();
    // eleven modes in fetch, eight in calculate, word and long, random operation figures
    for (i = 0; i < 44; i++) begin
      d = mk(modes[i % 11], i / 11 % 2 == 1, i / 22 == 1, rnd(5), (rnd(4) == 0 && i < 43) ? -2 : rnd(3), 0,
        rnd(2), 1 + rnd(2), 0, rnd(2) == 1);
      if (d.mode inside {EA_DN, EA_IMMW, EA_IMML}) d.calc = 1'h0;
      d.op_wr = d.op_wr_var ? 4'h0 : 4'(rnd(2));
      d.op_cyc = 8'(d.op_head + 2 * (d.op_rd + d.op_pf + d.op_wr + d.op_wr_var) + rnd(3) + 3);
      send(d, 1'h1);
    end
    quiesce();
    chk_val("run total", 16'(e_tot), run_total);
    // slow memory: only access counts and lengths are judged here
    slow = 1'h1;
    for (i = 0; i < 8; i++) begin
      d = mk(modes[rnd(11)], 1'h0, rnd(2) == 1, rnd(5), rnd(3), 12, rnd(2), 1, rnd(2), 1'h0);
      send(d, 1'h0);
    end
    quiesce();
    chk_val("reads", 16'(e_rd), 16'(n_rd));
    chk_val("fetches", 16'(e_pf), 16'(n_pf));
    chk_val("writes", 16'(e_wr), 16'(n_wr));
    chk_val("bad accesses", 16'h0, 16'(n_bad));
    summarize();
  end
endmodule // ea_bus_timing_scheduler_tb_top
